// file: verilog/aic_cfg.svh
// constants for the analogue input and configuration register bank
`ifndef AIC_CFG_SVH
`define AIC_CFG_SVH

// ---------------------------------------------------------------
// bus geometry
// ---------------------------------------------------------------
`define AIC_ADR_W        8
`define AIC_DAT_W        32
`define AIC_SEL_W        4
`define AIC_IDX_W        4
`define AIC_BYTE_W       8
`define AIC_IDX_MSB      5
`define AIC_IDX_LSB      2
`define AIC_ADR_HI_MSB   7
`define AIC_ADR_HI_LSB   6
`define AIC_ADR_LO_MSB   1
`define AIC_ADR_LO_LSB   0
`define AIC_ADR_ZERO     2'h0
`define AIC_LANE0        0
`define AIC_DAT_PAD      24'h00_0000

// ---------------------------------------------------------------
// register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define AIC_IDX_NONE     4'h0
`define AIC_IDX_INSEL    4'h4
`define AIC_IDX_ANA      4'h5
`define AIC_IDX_OP       4'h6
`define AIC_IDX_STAT     4'hf

// ---------------------------------------------------------------
// reset values and writable masks
// ---------------------------------------------------------------
`define AIC_RST_INSEL    2'h0
`define AIC_RST_ANA      8'h00
`define AIC_RST_OP       8'h00
`define AIC_MASK_INSEL   8'h03
`define AIC_MASK_ANA     8'h7b
`define AIC_MASK_OP      8'hbf
`define AIC_ZERO_BYTE    8'h00

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define AIC_INSEL_MSB    1
`define AIC_INSEL_LSB    0
`define AIC_REF_HI_BIT   6
`define AIC_IN_2X_BIT    5
`define AIC_MID_EN_BIT   4
`define AIC_REF_BUF_BIT  3
`define AIC_POS_BUF_BIT  1
`define AIC_NEG_BUF_BIT  0
`define AIC_WIDE_IN_BIT  7
`define AIC_PIN_FN_BIT   5
`define AIC_START_MSB    4
`define AIC_START_LSB    3
`define AIC_SPEED_BIT    2
`define AIC_STBY_BIT     1
`define AIC_PDOWN_BIT    0
`define AIC_STAT_PWR_MSB 1
`define AIC_STAT_PWR_LSB 0
`define AIC_STAT_2X_BIT  2

`endif

// file: verilog/aic_pkg.sv
// types shared by the register bank modules
`default_nettype none
package aic_pkg;

	typedef enum logic [1:0] {
		AIC_IN_NORMAL  = 2'h0,
		AIC_IN_INVERT  = 2'h1,
		AIC_IN_MIDTEST = 2'h2,
		AIC_IN_CMTEST  = 2'h3
	} aic_insel_t;

	typedef enum logic [1:0] {
		AIC_ST_STARTSTOP = 2'h0,
		AIC_ST_ONESHOT   = 2'h1,
		AIC_ST_SYNC      = 2'h2,
		AIC_ST_RSVD      = 2'h3
	} aic_start_t;

	typedef enum logic [1:0] {
		AIC_PWR_OFF     = 2'h0,
		AIC_PWR_STANDBY = 2'h1,
		AIC_PWR_ACTIVE  = 2'h2
	} aic_pwr_t;

	typedef struct packed {
		logic p_from_pos;
		logic p_from_neg;
		logic n_from_pos;
		logic n_from_neg;
		logic p_to_mid;
		logic n_to_mid;
	} aic_route_t;

endpackage

`default_nettype wire

// file: verilog/aic_bus_if.sv
// internal register access carrier between bus slave and register bank
`timescale 1ns/1ps
`default_nettype none
`include "aic_cfg.svh"

interface aic_bus_if;
	logic                   wr_stb;
	logic [`AIC_IDX_W-1:0]  idx;
	logic [`AIC_BYTE_W-1:0] wdata;
	logic [`AIC_BYTE_W-1:0] rdata;

	modport slave (output wr_stb, output idx, output wdata, input rdata);
	modport regs  (input wr_stb, input idx, input wdata, output rdata);
endinterface

`default_nettype wire

// file: verilog/aic_wb_slave.sv
// classic wishbone slave front end for the register bank
`timescale 1ns/1ps
`default_nettype none
`include "aic_cfg.svh"

module aic_wb_slave (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  cyc_i,
	input  wire logic                  stb_i,
	input  wire logic                  we_i,
	input  wire logic [`AIC_ADR_W-1:0] adr_i,
	input  wire logic [`AIC_SEL_W-1:0] sel_i,
	input  wire logic [`AIC_DAT_W-1:0] dat_i,
	output logic      [`AIC_DAT_W-1:0] dat_o,
	output logic                       ack_o,
	aic_bus_if.slave                   bus
);
	logic                  ack_reg;
	logic [`AIC_DAT_W-1:0] dat_reg;
	logic                  req;
	logic                  hit;

	// one access per request, ack drops the cycle after it rose
	assign req = cyc_i & stb_i & ~ack_reg;
	assign hit = (adr_i[`AIC_ADR_HI_MSB:`AIC_ADR_HI_LSB] == `AIC_ADR_ZERO) &&
		(adr_i[`AIC_ADR_LO_MSB:`AIC_ADR_LO_LSB] == `AIC_ADR_ZERO);

	assign bus.idx    = hit ? adr_i[`AIC_IDX_MSB:`AIC_IDX_LSB] : `AIC_IDX_NONE;
	assign bus.wr_stb = req & we_i & sel_i[`AIC_LANE0];
	assign bus.wdata  = dat_i[`AIC_BYTE_W-1:0];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_reg <= {`AIC_DAT_PAD, `AIC_ZERO_BYTE};
		end else if (req & ~we_i) begin
			dat_reg <= {`AIC_DAT_PAD, bus.rdata};
		end
	end

	assign ack_o = ack_reg;
	assign dat_o = dat_reg;
endmodule

`default_nettype wire

// file: verilog/aic_route_decode.sv
// input selection to converter input switch decode
`timescale 1ns/1ps
`default_nettype none

module aic_route_decode (
	input  wire aic_pkg::aic_insel_t insel_i,
	output aic_pkg::aic_route_t      route_o
);
	import aic_pkg::*;

	always_comb begin
		route_o = '0;
		case (insel_i)
			AIC_IN_NORMAL: begin
				route_o.p_from_pos = 1'b1;
				route_o.n_from_neg = 1'b1;
			end
			AIC_IN_INVERT: begin
				route_o.p_from_neg = 1'b1;
				route_o.n_from_pos = 1'b1;
			end
			AIC_IN_MIDTEST: begin
				// both pins open, converter inputs at midsupply
				route_o.p_to_mid = 1'b1;
				route_o.n_to_mid = 1'b1;
			end
			AIC_IN_CMTEST: begin
				// inputs shorted and tied to the positive pin
				route_o.p_from_pos = 1'b1;
				route_o.n_from_pos = 1'b1;
			end
			default: begin
				route_o = '0;
			end
		endcase
	end
endmodule

`default_nettype wire

// file: verilog/aic_regs.sv
// input select and configuration register bank with analogue controls
// Summary of operation
// [RULE_01] input select 00b routes normal polarity, 01b inverted polarity
// [RULE_02] input select 10b opens both pins, shorts converter to midsupply
// [RULE_03] input select 11b shorts converter inputs and ties them to positive pin
// [RULE_04] input select register at 4h, resets 00h, bits 7:2 read zero
// [RULE_05] analogue config at 5h, resets 00h, bits 7 and 2 read zero
// [RULE_06] bit 6 picks low reference range at 0, high at 1
// [RULE_07] high reference range forces effective input range to 1x
// [RULE_08] bit 5 picks 1x or 2x input range, subject to override
// [RULE_09] bit 4 enables the midsupply output pin
// [RULE_10] bit 3 enables the positive reference precharge buffer
// [RULE_11] bit 1 enables the positive input precharge buffer
// [RULE_12] bit 0 enables the negative input precharge buffer
// [RULE_13] operating config at 6h, resets 00h, fixed field layout, bit 6 reserved
// [RULE_14] start mode 00b start/stop, 01b one-shot, 10b synchronized, 11b reserved
// [RULE_15] speed bit 0 selects high speed, 1 selects low speed clock
// [RULE_16] standby bit powers converter down while conversions are stopped
// [RULE_17] power-down bit powers all but serial interface and register supply
// [RULE_18] reserved bit writes ignored, fields read back last written value
//
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "aic_cfg.svh"

module aic_regs (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  cyc_i,
	input  wire logic                  stb_i,
	input  wire logic                  we_i,
	input  wire logic [`AIC_ADR_W-1:0] adr_i,
	input  wire logic [`AIC_SEL_W-1:0] sel_i,
	input  wire logic [`AIC_DAT_W-1:0] dat_i,
	output logic      [`AIC_DAT_W-1:0] dat_o,
	output logic                       ack_o,
	input  wire logic                  conv_active_i,
	output logic                       adc_p_from_pos_o,
	output logic                       adc_p_from_neg_o,
	output logic                       adc_n_from_pos_o,
	output logic                       adc_n_from_neg_o,
	output logic                       adc_p_to_mid_o,
	output logic                       adc_n_to_mid_o,
	output logic                       ref_high_range_o,
	output logic                       input_range_2x_o,
	output logic                       midsupply_output_en_o,
	output logic                       ref_pos_precharge_en_o,
	output logic                       pos_input_precharge_en_o,
	output logic                       neg_input_precharge_en_o,
	output logic                       range_extension_o,
	output logic                       output_pin_dual_o,
	output logic                       start_stop_mode_o,
	output logic                       one_shot_mode_o,
	output logic                       sync_mode_o,
	output logic                       low_speed_o,
	output logic                       analog_power_en_o,
	output logic                       modulator_power_en_o,
	output aic_pkg::aic_pwr_t          power_state_o
);
	import aic_pkg::*;

	// ---------------------------------------------------------------
	// bus front end
	// ---------------------------------------------------------------
	aic_bus_if bus ();

	aic_wb_slave u_slave (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.cyc_i (cyc_i),
		.stb_i (stb_i),
		.we_i  (we_i),
		.adr_i (adr_i),
		.sel_i (sel_i),
		.dat_i (dat_i),
		.dat_o (dat_o),
		.ack_o (ack_o),
		.bus   (bus)
	);

	// ---------------------------------------------------------------
	// software registers
	// ---------------------------------------------------------------
	aic_insel_t             insel_reg;
	logic [`AIC_BYTE_W-1:0] ana_cfg_reg;
	logic [`AIC_BYTE_W-1:0] op_cfg_reg;
	aic_pwr_t               pwr_reg;
	aic_pwr_t               pwr_next;
	logic                   wr_insel;
	logic                   wr_ana;
	logic                   wr_op;
	logic                   range_2x_next;
	logic [`AIC_BYTE_W-1:0] stat_byte;

	assign wr_insel = bus.wr_stb && (bus.idx == `AIC_IDX_INSEL);
	assign wr_ana   = bus.wr_stb && (bus.idx == `AIC_IDX_ANA);
	assign wr_op    = bus.wr_stb && (bus.idx == `AIC_IDX_OP);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			insel_reg <= aic_insel_t'(`AIC_RST_INSEL); // see [RULE_04]
		end else if (wr_insel) begin
			insel_reg <= aic_insel_t'(bus.wdata[`AIC_INSEL_MSB:`AIC_INSEL_LSB]);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ana_cfg_reg <= `AIC_RST_ANA; // see [RULE_05]
		end else if (wr_ana) begin
			ana_cfg_reg <= bus.wdata & `AIC_MASK_ANA; // see [RULE_18]
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			op_cfg_reg <= `AIC_RST_OP; // see [RULE_13]
		end else if (wr_op) begin
			op_cfg_reg <= bus.wdata & `AIC_MASK_OP; // see [RULE_18]
		end
	end

	// ---------------------------------------------------------------
	// read back
	// ---------------------------------------------------------------
	always_comb begin
		stat_byte = `AIC_ZERO_BYTE;
		stat_byte[`AIC_STAT_PWR_MSB:`AIC_STAT_PWR_LSB] = pwr_reg;
		stat_byte[`AIC_STAT_2X_BIT] = input_range_2x_o;
	end

	always_comb begin
		case (bus.idx)
			`AIC_IDX_INSEL: begin
				// upper bits always zero
				bus.rdata = {{(`AIC_BYTE_W-2){1'b0}}, insel_reg}; // see [RULE_04]
			end
			`AIC_IDX_ANA: begin
				bus.rdata = ana_cfg_reg; // see [RULE_05]
			end
			`AIC_IDX_OP: begin
				bus.rdata = op_cfg_reg;
			end
			`AIC_IDX_STAT: begin
				bus.rdata = stat_byte;
			end
			default: begin
				bus.rdata = `AIC_ZERO_BYTE;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// input switch control
	// ---------------------------------------------------------------
	aic_route_t route;

	aic_route_decode u_route (
		.insel_i (insel_reg),
		.route_o (route)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			adc_p_from_pos_o <= 1'b0;
			adc_p_from_neg_o <= 1'b0;
			adc_n_from_pos_o <= 1'b0;
			adc_n_from_neg_o <= 1'b0;
			adc_p_to_mid_o   <= 1'b0;
			adc_n_to_mid_o   <= 1'b0;
		end else begin
			adc_p_from_pos_o <= route.p_from_pos; // see [RULE_01]
			adc_p_from_neg_o <= route.p_from_neg; // see [RULE_01]
			adc_n_from_pos_o <= route.n_from_pos; // see [RULE_03]
			adc_n_from_neg_o <= route.n_from_neg;
			adc_p_to_mid_o   <= route.p_to_mid; // see [RULE_02]
			adc_n_to_mid_o   <= route.n_to_mid; // see [RULE_02]
		end
	end

	// ---------------------------------------------------------------
	// analogue front end control
	// ---------------------------------------------------------------
	// high reference range overrides the range bit
	assign range_2x_next = ana_cfg_reg[`AIC_IN_2X_BIT] &
		~ana_cfg_reg[`AIC_REF_HI_BIT]; // see [RULE_07]

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ref_high_range_o         <= 1'b0;
			input_range_2x_o         <= 1'b0;
			midsupply_output_en_o    <= 1'b0;
			ref_pos_precharge_en_o   <= 1'b0;
			pos_input_precharge_en_o <= 1'b0;
			neg_input_precharge_en_o <= 1'b0;
		end else begin
			ref_high_range_o         <= ana_cfg_reg[`AIC_REF_HI_BIT]; // see [RULE_06]
			input_range_2x_o         <= range_2x_next; // see [RULE_08]
			midsupply_output_en_o    <= ana_cfg_reg[`AIC_MID_EN_BIT]; // see [RULE_09]
			ref_pos_precharge_en_o   <= ana_cfg_reg[`AIC_REF_BUF_BIT]; // see [RULE_10]
			pos_input_precharge_en_o <= ana_cfg_reg[`AIC_POS_BUF_BIT]; // see [RULE_11]
			neg_input_precharge_en_o <= ana_cfg_reg[`AIC_NEG_BUF_BIT]; // see [RULE_12]
		end
	end

	// ---------------------------------------------------------------
	// operating mode control
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			range_extension_o <= 1'b0;
			output_pin_dual_o <= 1'b0;
			low_speed_o       <= 1'b0;
		end else begin
			range_extension_o <= op_cfg_reg[`AIC_WIDE_IN_BIT];
			output_pin_dual_o <= op_cfg_reg[`AIC_PIN_FN_BIT];
			low_speed_o       <= op_cfg_reg[`AIC_SPEED_BIT]; // see [RULE_15]
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			start_stop_mode_o <= 1'b1;
			one_shot_mode_o   <= 1'b0;
			sync_mode_o       <= 1'b0;
		end else begin
			start_stop_mode_o <= 1'b0;
			one_shot_mode_o   <= 1'b0;
			sync_mode_o       <= 1'b0;
			// reserved code selects no start mode
			case (aic_start_t'(op_cfg_reg[`AIC_START_MSB:`AIC_START_LSB]))
				AIC_ST_STARTSTOP: start_stop_mode_o <= 1'b1; // see [RULE_14]
				AIC_ST_ONESHOT:   one_shot_mode_o   <= 1'b1; // see [RULE_14]
				AIC_ST_SYNC:      sync_mode_o       <= 1'b1; // see [RULE_14]
				default:          start_stop_mode_o <= 1'b0;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// power state
	// ---------------------------------------------------------------
	always_comb begin
		if (op_cfg_reg[`AIC_PDOWN_BIT]) begin
			pwr_next = AIC_PWR_OFF; // see [RULE_17]
		end else if (op_cfg_reg[`AIC_STBY_BIT] && !conv_active_i) begin
			pwr_next = AIC_PWR_STANDBY; // see [RULE_16]
		end else begin
			pwr_next = AIC_PWR_ACTIVE;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pwr_reg <= AIC_PWR_ACTIVE;
		end else begin
			pwr_reg <= pwr_next;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			analog_power_en_o    <= 1'b1;
			modulator_power_en_o <= 1'b1;
			power_state_o        <= AIC_PWR_ACTIVE;
		end else begin
			power_state_o <= pwr_reg;
			case (pwr_reg)
				AIC_PWR_OFF: begin
					analog_power_en_o    <= 1'b0; // see [RULE_17]
					modulator_power_en_o <= 1'b0;
				end
				AIC_PWR_STANDBY: begin
					analog_power_en_o    <= 1'b1;
					modulator_power_en_o <= 1'b0; // see [RULE_16]
				end
				default: begin
					analog_power_en_o    <= 1'b1;
					modulator_power_en_o <= 1'b1;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	normal_route_a: assert property ( // see [RULE_01]
		(insel_reg == AIC_IN_NORMAL) |=> adc_p_from_pos_o && adc_n_from_neg_o
			&& !adc_p_from_neg_o && !adc_n_from_pos_o && !adc_p_to_mid_o)
		else $error("normal routing wrong");

	invert_route_a: assert property ( // see [RULE_01]
		(insel_reg == AIC_IN_INVERT) |=> adc_p_from_neg_o && adc_n_from_pos_o
			&& !adc_p_from_pos_o && !adc_n_from_neg_o && !adc_n_to_mid_o)
		else $error("inverted routing wrong");

	mid_test_a: assert property ( // see [RULE_02]
		(insel_reg == AIC_IN_MIDTEST) |=> adc_p_to_mid_o && adc_n_to_mid_o
			&& !adc_p_from_pos_o && !adc_p_from_neg_o
			&& !adc_n_from_pos_o && !adc_n_from_neg_o)
		else $error("midsupply test routing wrong");

	cm_test_a: assert property ( // see [RULE_03]
		(insel_reg == AIC_IN_CMTEST) |=> adc_p_from_pos_o && adc_n_from_pos_o
			&& !adc_p_from_neg_o && !adc_n_from_neg_o && !adc_p_to_mid_o)
		else $error("common-mode test routing wrong");

	insel_upper_a: assert property ( // see [RULE_04]
		(bus.idx == `AIC_IDX_INSEL) |->
			((bus.rdata & ~`AIC_MASK_INSEL) == `AIC_ZERO_BYTE))
		else $error("input select upper bits not zero");

	reset_values_a: assert property ( // see [RULE_13]
		$past(rst_i) |-> (insel_reg == AIC_IN_NORMAL)
			&& (ana_cfg_reg == `AIC_RST_ANA) && (op_cfg_reg == `AIC_RST_OP))
		else $error("register reset value wrong");

	ana_rsvd_a: assert property ( // see [RULE_05]
		(ana_cfg_reg & ~`AIC_MASK_ANA) == `AIC_ZERO_BYTE)
		else $error("analogue config reserved bit set");

	ref_range_a: assert property ( // see [RULE_06]
		ana_cfg_reg[`AIC_REF_HI_BIT] |=> ref_high_range_o ##1
			(ref_high_range_o == $past(ana_cfg_reg[`AIC_REF_HI_BIT])))
		else $error("reference range output wrong");

	range_override_a: assert property ( // see [RULE_07]
		ref_high_range_o |-> !input_range_2x_o)
		else $error("2x range with high reference");

	inp_range_a: assert property ( // see [RULE_08]
		(ana_cfg_reg[`AIC_IN_2X_BIT] && !ana_cfg_reg[`AIC_REF_HI_BIT])
			|=> input_range_2x_o)
		else $error("2x input range not applied");

	mid_out_a: assert property ( // see [RULE_09]
		$rose(ana_cfg_reg[`AIC_MID_EN_BIT]) |=> midsupply_output_en_o)
		else $error("midsupply output not enabled");

	ref_buf_a: assert property ( // see [RULE_10]
		ref_pos_precharge_en_o == $past(ana_cfg_reg[`AIC_REF_BUF_BIT]))
		else $error("reference buffer enable wrong");

	pos_buf_a: assert property ( // see [RULE_11]
		$fell(ana_cfg_reg[`AIC_POS_BUF_BIT]) |=> !pos_input_precharge_en_o)
		else $error("positive input buffer not disabled");

	neg_buf_a: assert property ( // see [RULE_12]
		neg_input_precharge_en_o |-> $past(ana_cfg_reg[`AIC_NEG_BUF_BIT]))
		else $error("negative input buffer enable wrong");

	start_rsvd_a: assert property ( // see [RULE_14]
		(op_cfg_reg[`AIC_START_MSB:`AIC_START_LSB] == AIC_ST_RSVD) |=>
			!start_stop_mode_o && !one_shot_mode_o && !sync_mode_o)
		else $error("reserved start mode selected a mode");

	speed_a: assert property ( // see [RULE_15]
		$rose(op_cfg_reg[`AIC_SPEED_BIT]) |=> low_speed_o)
		else $error("low speed not selected");

	standby_a: assert property ( // see [RULE_16]
		(op_cfg_reg[`AIC_STBY_BIT] && !op_cfg_reg[`AIC_PDOWN_BIT]
			&& !conv_active_i) |-> ##2 !modulator_power_en_o && analog_power_en_o)
		else $error("standby did not power down converter");

	power_down_a: assert property ( // see [RULE_17]
		op_cfg_reg[`AIC_PDOWN_BIT] |-> ##2 !analog_power_en_o
			&& !modulator_power_en_o)
		else $error("power-down not applied");

	op_hold_a: assert property ( // see [RULE_18]
		!wr_op |=> $stable(op_cfg_reg))
		else $error("operating config changed without write");

	op_write_a: assert property ( // see [RULE_18]
		wr_op |=> (op_cfg_reg == ($past(bus.wdata) & `AIC_MASK_OP)))
		else $error("operating config write wrong");
endmodule

`default_nettype wire

// file: bench/adc_input_and_config_registers_tb.sv
// self-checking bench for the input select and configuration registers
`timescale 1ns/1ps
`default_nettype none
`include "aic_cfg.svh"

module adc_input_and_config_registers_tb;
	import aic_pkg::*;

	// ---------------------------------------------------------------
	// stimulus, observation and score
	// ---------------------------------------------------------------
	logic                   clk_i       = 1'b0;
	logic                   rst_i       = 1'b1;
	logic                   cyc_i       = 1'b0;
	logic                   stb_i       = 1'b0;
	logic                   we_i        = 1'b0;
	logic [`AIC_ADR_W-1:0]  adr_i       = '0;
	logic [`AIC_SEL_W-1:0]  sel_i       = '0;
	logic [`AIC_DAT_W-1:0]  dat_i       = '0;
	logic                   conv_active = 1'b0;
	wire  [`AIC_DAT_W-1:0]  dat_o;
	wire                    ack_o;
	wire  [21:0]            outs;
	logic [7:0]             sh [4:6];
	logic [31:0]            seed        = 32'h3ace_bf3b;
	int                     fails       = 0;
	int                     compares    = 0;
	int                     cycles      = 0;

	always #2 clk_i = ~clk_i;

	aic_regs i_dut (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .conv_active_i(conv_active),
		.adc_p_from_pos_o(outs[21]), .adc_p_from_neg_o(outs[20]),
		.adc_n_from_pos_o(outs[19]), .adc_n_from_neg_o(outs[18]),
		.adc_p_to_mid_o(outs[17]), .adc_n_to_mid_o(outs[16]),
		.ref_high_range_o(outs[15]), .input_range_2x_o(outs[14]),
		.midsupply_output_en_o(outs[13]),
		.ref_pos_precharge_en_o(outs[12]),
		.pos_input_precharge_en_o(outs[11]),
		.neg_input_precharge_en_o(outs[10]),
		.range_extension_o(outs[9]), .output_pin_dual_o(outs[8]),
		.start_stop_mode_o(outs[7]), .one_shot_mode_o(outs[6]),
		.sync_mode_o(outs[5]), .low_speed_o(outs[4]),
		.analog_power_en_o(outs[3]), .modulator_power_en_o(outs[2]),
		.power_state_o(outs[1:0])
	);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [21:0] expo(input logic [7:0] s, a, o,
			input logic c);
		logic [5:0] r;
		logic       sb;
		logic [1:0] st;
		case (s[1:0])
			2'h0: r = 6'b100100;
			2'h1: r = 6'b011000;
			2'h2: r = 6'b000011;
			default: r = 6'b101000;
		endcase
		sb = ~o[0] & o[1] & ~c;
		st = o[0] ? 2'h0 : (sb ? 2'h1 : 2'h2);
		return {r, a[6], a[5] & ~a[6], a[4], a[3], a[1], a[0], o[7], o[5],
			o[4:3] == 2'h0, o[4:3] == 2'h1, o[4:3] == 2'h2, o[2],
			~o[0], ~o[0] & ~sb, st};
	endfunction

	task automatic test_done();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, g);
		compares++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a,
			input logic [31:0] d, input logic [3:0] s,
			output logic [31:0] q);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= s;
		@(posedge clk_i);
		while (ack_o !== 1'b1)
			@(posedge clk_i);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask

	// write one register, keep the shadow, read it back
	task automatic put(input int i, input logic [7:0] d);
		logic [31:0] q;
		logic [31:0] r;
		r = rnd();
		wb(1'b1, 8'(i * 4), {r[31:8], d}, 4'hf, q);
		sh[i] = d & (i == 4 ? `AIC_MASK_INSEL :
			i == 5 ? `AIC_MASK_ANA : `AIC_MASK_OP);
		wb(1'b0, 8'(i * 4), 32'h0000_0000, 4'hf, q);
		chk("readback", {24'h00_0000, sh[i]}, q);
	endtask

	// pins, then the status word: power state and effective 2x range
	task automatic chk_out();
		logic [31:0] q;
		logic [21:0] e;
		repeat (3) @(posedge clk_i);
		e = expo(sh[4], sh[5], sh[6], conv_active);
		chk("outputs", {10'h000, e}, {10'h000, outs});
		wb(1'b0, 8'h3c, 32'h0000_0000, 4'hf, q);
		chk("status", {29'h0000_0000, e[14], e[1:0]}, q);
	endtask

	task automatic chk_regs();
		logic [31:0] q;
		for (int i = 4; i < 7; i++) begin
			wb(1'b0, 8'(i * 4), 32'h0000_0000, 4'hf, q);
			chk("register", {24'h00_0000, sh[i]}, q);
		end
		chk_out();
	endtask

	task automatic do_reset();
		@(posedge clk_i);
		rst_i <= 1'b1;
		conv_active <= 1'b0;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		sh[4] = 8'h00;
		sh[5] = 8'h00;
		sh[6] = 8'h00;
	endtask

	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			fails++;
			test_done();
		end
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		logic [31:0] q;
		logic [7:0]  r;
		static logic [7:0] ac [5] = '{8'h60, 8'h20, 8'h40, 8'hff, 8'h84};
		static logic [7:0] un [4] = '{8'h00, 8'h1c, 8'h11, 8'h50};
		do_reset();
		chk_regs();
		for (int k = 0; k < 4; k++) begin
			put(4, (8'(rnd()) & 8'hfc) | 8'(k));
			chk_out();
		end
		for (int k = 0; k < 5; k++) begin
			put(5, ac[k]);
			chk_out();
		end
		for (int k = 0; k < 32; k++) begin
			r = 8'(rnd());
			conv_active <= k[4];
			put(6, {r[7], 1'b1, r[5], k[1:0], r[2], k[2], k[3]});
			chk_out();
		end
		for (int k = 0; k < 40; k++) begin
			r = 8'(rnd());
			conv_active <= r[0];
			put(4 + int'(rnd() % 3), 8'(rnd()));
			chk_out();
		end
		wb(1'b1, 8'h10, 32'h0000_00ff, 4'he, q);
		for (int k = 0; k < 4; k++) begin
			wb(1'b1, un[k], 32'hffff_ffff, 4'hf, q);
			wb(1'b0, un[k], 32'h0000_0000, 4'hf, q);
			chk("unmapped", 32'h0000_0000, q);
		end
		chk_regs();
		put(5, 8'hff);
		put(6, 8'hff);
		do_reset();
		chk_regs();
		test_done();
	end
endmodule

`default_nettype wire
